// *** cpu_core_registers_flags_tb.sv ***
/*
  cpu_core_registers_flags_tb.sv: self-checking bench driving the core over axi4-lite.
  assumes: crf_core, crf_req_model and crf_core_monitor compiled before it.
*/
`timescale 1ns/1ps
`include "crf_consts.svh"
module cpu_core_registers_flags_tb;
  logic clock, arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdat;
  logic [3:0] wstrb, irq_set, irq_req;
  logic [1:0] resp;
  logic brk_set, break_req, break_enable, monitor_mode, stop_req, in_break;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] operand_addr;
  int fails, cmp_count;

  crf_core dut (.clock(clock), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(rready), .irq_req(irq_req), .break_enable(break_enable),
    .break_req(break_req), .monitor_mode(monitor_mode), .stop_req(stop_req),
    .in_break(in_break), .operand_addr(operand_addr));
  crf_req_model u_req (.clock(clock), .arst_n(arst_n), .irq_set(irq_set),
    .brk_set(brk_set), .in_break(in_break), .irq_req(irq_req), .break_req(break_req));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic timeout;
    fails++;
    $display("Error at %0t: wait ran out", $time);
    stop_test();
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= {24'h0, a};
    wdata <= d;
    wstrb <= (a == `CRF_OFF_MEMDATA) ? 4'h3 : 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awready) awvalid <= 1'b0;
      if (s_axi_wready) wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    if (!s_axi_bvalid) timeout();
    resp = s_axi_bresp;
    bready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arready) arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    if (!s_axi_rvalid) timeout();
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wchk(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    chk({30'h0, resp}, 32'h0);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask

  task automatic cmd(input logic [4:0] op);
    wchk(`CRF_OFF_CMD, {27'h0, op});
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    repeat (4) @(posedge clock);
    rd(`CRF_OFF_IRQ);
    while (rdat[3] !== 1'b1 && n < 40) begin
      rd(`CRF_OFF_IRQ);
      n++;
    end
    if (rdat[3] !== 1'b1) timeout();
  endtask

  task automatic alu(input logic [4:0] op, input logic [7:0] a, m, es, ef);
    wchk(`CRF_OFF_SUM, {24'h0, a});
    wchk(`CRF_OFF_OPERAND, {24'h0, m});
    cmd(op);
    rc(`CRF_OFF_SUM, {24'h0, es});
    rc(`CRF_OFF_FLAG, {24'h0, ef});
  endtask

  task automatic do_reset;
    arst_n <= 1'b0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask

  initial begin
    arst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, brk_set, break_enable} = '0;
    {awaddr, wdata, araddr, wstrb, irq_set, monitor_mode, stop_req} = '0;
    fails = 0;
    cmp_count = 0;
    do_reset();
    // vector image, then a second reset picks it up
    wchk(`CRF_OFF_MEMDATA, 32'hfe12);
    wchk(`CRF_OFF_MEMDATA, 32'hff34);
    wchk(`CRF_OFF_MEMDATA, 32'hf8ab);
    wchk(`CRF_OFF_MEMDATA, 32'hf9cd);
    wchk(`CRF_OFF_MEMDATA, 32'hfc0c);
    wchk(`CRF_OFF_MEMDATA, 32'hfd0d);
    do_reset();
    rc(`CRF_OFF_FETCH, 32'h1234);
    rc(`CRF_OFF_STACK, 32'h00ff);
    rc(`CRF_OFF_FLAG, 32'h68);
    $display("reset test done");
    stop_req <= 1'b1;
    alu(crf_pkg::CRF_OP_ADD, 8'h7f, 8'h01, 8'h80, 8'hfc);
    alu(crf_pkg::CRF_OP_ADD, 8'hff, 8'h01, 8'h00, 8'h7b);
    alu(crf_pkg::CRF_OP_SUB, 8'h00, 8'h01, 8'hff, 8'h7d);
    alu(crf_pkg::CRF_OP_AND, 8'hf0, 8'h0f, 8'h00, 8'h7b);
    alu(crf_pkg::CRF_OP_ADC, 8'h08, 8'h08, 8'h11, 8'h78);
    alu(crf_pkg::CRF_OP_ADC, 8'h01, 8'h01, 8'h02, 8'h68);
    alu(crf_pkg::CRF_OP_ASL, 8'h81, 8'h00, 8'h02, 8'he9);
    alu(crf_pkg::CRF_OP_ROR, 8'h02, 8'h00, 8'h81, 8'hec);
    alu(crf_pkg::CRF_OP_DAA, 8'h9b, 8'h00, 8'h01, 8'he9);
    cmd(crf_pkg::CRF_OP_FETCH);
    rc(`CRF_OFF_FETCH, 32'h1235);
    wchk(`CRF_OFF_OPERAND, 32'h4000);
    cmd(crf_pkg::CRF_OP_JUMP);
    rc(`CRF_OFF_FETCH, 32'h4000);
    cmd(crf_pkg::CRF_OP_STOP);
    rc(`CRF_OFF_FETCH, 32'h4000);
    stop_req <= 1'b0;
    $display("alu test done");
    wchk(`CRF_OFF_STACK, 32'h1234);
    wchk(`CRF_OFF_SUM, 32'h5a);
    cmd(crf_pkg::CRF_OP_PUSH_A);
    rc(`CRF_OFF_STACK, 32'h1233);
    wchk(`CRF_OFF_SUM, 32'h0);
    cmd(crf_pkg::CRF_OP_PULL_A);
    rc(`CRF_OFF_SUM, 32'h5a);
    rc(`CRF_OFF_STACK, 32'h1234);
    wchk(`CRF_OFF_OPERAND, 32'h0110);
    cmd(crf_pkg::CRF_OP_SPADR1);
    rc(`CRF_OFF_STATUS, 32'h1244);
    cmd(crf_pkg::CRF_OP_SPADR2);
    rc(`CRF_OFF_STATUS, 32'h1344);
    chk({16'h0, operand_addr}, 32'h1344);
    cmd(crf_pkg::CRF_OP_RSP);
    rc(`CRF_OFF_STACK, 32'h12ff);
    wchk(`CRF_OFF_OPERAND, 32'h9a3c);
    cmd(crf_pkg::CRF_OP_LDHX);
    rc(`CRF_OFF_INDEX, 32'h9a3c);
    cmd(crf_pkg::CRF_OP_PUSH_H);
    rc(`CRF_OFF_STACK, 32'h12fe);
    wchk(`CRF_OFF_INDEX, 32'h0);
    cmd(crf_pkg::CRF_OP_PULL_H);
    rc(`CRF_OFF_INDEX, 32'h9a00);
    rc(`CRF_OFF_STACK, 32'h12ff);
    $display("stack test done");
    wchk(`CRF_OFF_STACK, 32'h0080);
    wchk(`CRF_OFF_INDEX, 32'h5566);
    irq_set <= 4'b0110;
    repeat (20) @(posedge clock);
    rc(`CRF_OFF_FETCH, 32'h4000);
    cmd(crf_pkg::CRF_OP_CLI);
    wait_idle();
    rc(`CRF_OFF_FETCH, 32'habcd);
    rc(`CRF_OFF_STACK, 32'h007b);
    rc(`CRF_OFF_FLAG, 32'he9);
    wchk(`CRF_OFF_INDEX, 32'h7711);
    irq_set <= 4'b0000;
    cmd(crf_pkg::CRF_OP_RTI);
    wait_idle();
    rc(`CRF_OFF_FLAG, 32'he1);
    rc(`CRF_OFF_STACK, 32'h0080);
    rc(`CRF_OFF_INDEX, 32'h7766);
    rc(`CRF_OFF_FETCH, 32'h4000);
    cmd(crf_pkg::CRF_OP_SEI);
    rc(`CRF_OFF_FLAG, 32'he9);
    $display("interrupt test done");
    brk_set <= 1'b1;
    monitor_mode <= 1'b1;
    cmd(crf_pkg::CRF_OP_NOP);
    repeat (12) @(posedge clock);
    chk({31'h0, in_break}, 32'h0);
    break_enable <= 1'b1;
    cmd(crf_pkg::CRF_OP_NOP);
    wait_idle();
    chk({31'h0, in_break}, 32'h1);
    rc(`CRF_OFF_FETCH, 32'h0c0d);
    brk_set <= 1'b0;
    cmd(crf_pkg::CRF_OP_RTI);
    wait_idle();
    chk({31'h0, in_break}, 32'h0);
    rc(`CRF_OFF_STACK, 32'h0080);
    cmd(crf_pkg::CRF_OP_SWI);
    wait_idle();
    chk({31'h0, in_break}, 32'h0);
    rc(`CRF_OFF_FETCH, 32'h0c0d);
    rc(`CRF_OFF_STACK, 32'h007b);
    $display("break test done");
    rd(8'h40);
    chk({30'h0, resp}, 32'h2);
    wr(8'h02, 32'h0);
    chk({30'h0, resp}, 32'h2);
    $display("refusal test done");
    stop_test();
  end
endmodule // cpu_core_registers_flags_tb

// *** crf_consts.svh ***
/*
  crf_consts.svh: offsets, field positions, reset values and vectors of the
  core register and flag block.
  assumes: included by the core design file and by the bench.
*/
`ifndef CRF_CONSTS_SVH
`define CRF_CONSTS_SVH

// axi register offsets (byte addresses)
`define CRF_OFF_SUM     8'h00
`define CRF_OFF_INDEX   8'h04
`define CRF_OFF_STACK   8'h08
`define CRF_OFF_FETCH   8'h0c
`define CRF_OFF_FLAG    8'h10
`define CRF_OFF_CMD     8'h14
`define CRF_OFF_OPERAND 8'h18
`define CRF_OFF_STATUS  8'h1c
`define CRF_OFF_IRQ     8'h20
`define CRF_OFF_MEMDATA 8'h24

// flag register bit positions
`define CRF_FLG_C 0
`define CRF_FLG_Z 1
`define CRF_FLG_N 2
`define CRF_FLG_I 3
`define CRF_FLG_H 4
`define CRF_FLG_V 7

// reset values and vectors
`define CRF_STACK_RESET 16'h00ff
`define CRF_STACK_LOW   8'hff
`define CRF_FLAG_ONES   8'h60
`define CRF_FLAG_RESET  8'h68
`define CRF_VEC_RESET   16'hfffe
`define CRF_VEC_TRAP    16'hfffc
`define CRF_VEC_TRAP_MON 16'hfefc

`endif

// *** crf_core.sv ***
/*
  crf_core.sv: register set, result flags, interrupt mask sequence, reset
  vector load and break trap of a small 8-bit cpu core, with an axi4-lite
  register slave standing in for the instruction decoder.
  assumes: one 40 mhz clock; axi master follows axi4-lite; stack and vector
  memory is modelled by an internal byte array written through memdata.
*/
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
// Behaviour
// - 8-bit sum register holds operands, results
// - index pair is upper and lower byte
// - reset presets stack top pointer to 00ff
// - stack low preset forces low byte ff
// - push decrements, pull increments stack pointer
// - stack-relative address is pointer plus offset
// - fetch counter increments, jumps load target
// - reset loads fetch counter from fffe vector
// - flag bits 6 and 5 read one
// - overflow flag from two's complement overflow
// - half carry from bit 3 into 4
// - mask blocks interrupts, set before vector fetch
// - interrupt entry never stacks upper index
// - highest-priority pending request served first
// - return pulls registers and mask back
// - reset sets mask, only release clears; code also clears it on a flag register write and on rti pulling a clear mask
// - negative flag follows result bit 7
// - zero flag when result is 00
// - carry on carry-out or borrow
// - break becomes soft trap, monitor vector
// - return ends break once request drops
// - stop request has no effect
`timescale 1ns/1ps
`include "crf_consts.svh"

module crf_core (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] irq_req,
  input wire logic break_enable,
  input wire logic break_req,
  input wire logic monitor_mode,
  input wire logic stop_req,
  output logic in_break,
  output logic [15:0] operand_addr
);

  logic rst_s1_q, rst_n_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  logic [7:0] sum_q;
  logic [15:0] index_q;
  logic [15:0] sp_q;
  logic [15:0] pc_q;
  logic [7:0] flag_q;
  logic [15:0] operand_q;
  logic [7:0] mem [0:255];
  crf_pkg::crf_state_e state_q;
  logic [2:0] step_q;
  logic [3:0] irq_taken_q;
  logic [15:0] vec_q;
  logic trap_q;

  // axi write channel capture, either order
  logic aw_have_q, w_have_q;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic wr_go;
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      ws_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known(aw_q) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic known(input logic [7:0] a);
    known = (a <= `CRF_OFF_MEMDATA) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [15:0] put16(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    put16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // command decode from bus writes
  logic cmd_go;
  crf_pkg::crf_op_e cmd;
  assign cmd_go = wr_go && aw_q == `CRF_OFF_CMD && ws_q[0];
  assign cmd = crf_pkg::crf_op_e'(w_q[4:0]);

  // alu
  logic [7:0] m;
  logic [8:0] sum9;
  logic [4:0] nib;
  logic [7:0] res;
  logic [7:0] flag_d;
  logic [7:0] daa_fix;
  assign m = operand_q[7:0];

  always_comb begin
    flag_d = flag_q;
    res = sum_q;
    sum9 = 9'h0;
    nib = 5'h0;
    daa_fix = 8'h00;
    case (cmd)
      crf_pkg::CRF_OP_ADD, crf_pkg::CRF_OP_ADC: begin
        sum9 = {1'b0, sum_q} + {1'b0, m} +
               {8'h00, cmd == crf_pkg::CRF_OP_ADC && flag_q[`CRF_FLG_C]};
        nib = {1'b0, sum_q[3:0]} + {1'b0, m[3:0]} +
              {4'h0, cmd == crf_pkg::CRF_OP_ADC && flag_q[`CRF_FLG_C]};
        res = sum9[7:0];
        flag_d[`CRF_FLG_H] = nib[4];
        flag_d[`CRF_FLG_C] = sum9[8];
        flag_d[`CRF_FLG_V] = (sum_q[7] == m[7]) && (res[7] != sum_q[7]);
      end
      crf_pkg::CRF_OP_SUB: begin
        sum9 = {1'b0, sum_q} - {1'b0, m};
        res = sum9[7:0];
        flag_d[`CRF_FLG_C] = sum9[8];
        flag_d[`CRF_FLG_V] = (sum_q[7] != m[7]) && (res[7] != sum_q[7]);
      end
      crf_pkg::CRF_OP_AND: begin
        res = sum_q & m;
        flag_d[`CRF_FLG_V] = 1'b0;
      end
      crf_pkg::CRF_OP_LDA, crf_pkg::CRF_OP_PULL_A: begin
        res = cmd == crf_pkg::CRF_OP_LDA ? m : mem[sp_q[7:0] + 8'h01];
        if (cmd == crf_pkg::CRF_OP_LDA) begin
          flag_d[`CRF_FLG_V] = 1'b0;
        end
      end
      crf_pkg::CRF_OP_ASL: begin
        res = {sum_q[6:0], 1'b0};
        flag_d[`CRF_FLG_C] = sum_q[7];
        flag_d[`CRF_FLG_V] = sum_q[7] ^ sum_q[6];
      end
      crf_pkg::CRF_OP_ROR: begin
        res = {flag_q[`CRF_FLG_C], sum_q[7:1]};
        flag_d[`CRF_FLG_C] = sum_q[0];
        flag_d[`CRF_FLG_V] = flag_q[`CRF_FLG_C] ^ sum_q[0];
      end
      crf_pkg::CRF_OP_DAA: begin
        daa_fix[3:0] = (flag_q[`CRF_FLG_H] || sum_q[3:0] > 4'h9) ? 4'h6 : 4'h0;
        daa_fix[7:4] = (flag_q[`CRF_FLG_C] || sum_q > 8'h99) ? 4'h6 : 4'h0;
        res = sum_q + daa_fix;
        flag_d[`CRF_FLG_C] = flag_q[`CRF_FLG_C] || sum_q > 8'h99;
      end
      default: begin
        res = sum_q;
      end
    endcase
    case (cmd)
      crf_pkg::CRF_OP_ADD, crf_pkg::CRF_OP_ADC, crf_pkg::CRF_OP_SUB, crf_pkg::CRF_OP_AND,
      crf_pkg::CRF_OP_LDA, crf_pkg::CRF_OP_ASL, crf_pkg::CRF_OP_ROR,
      crf_pkg::CRF_OP_DAA, crf_pkg::CRF_OP_PULL_A: begin
        flag_d[`CRF_FLG_N] = res[7];
        flag_d[`CRF_FLG_Z] = res == 8'h00;
      end
      default: begin
        flag_d[`CRF_FLG_N] = flag_q[`CRF_FLG_N];
      end
    endcase
  end

  // interrupt selection, lowest index has highest priority
  logic [3:0] irq_pick;
  always_comb begin
    irq_pick = 4'h0;
    for (int i = 3; i >= 0; i--) begin
      if (irq_req[i]) begin
        irq_pick = 4'(1 << i);
      end
    end
  end

  logic irq_go, trap_go;
  assign irq_go = state_q == crf_pkg::CRF_ST_IDLE && !flag_q[`CRF_FLG_I] && irq_pick != 4'h0
                  && !cmd_go;
  assign trap_go = state_q == crf_pkg::CRF_ST_IDLE && cmd_go &&
                   (cmd == crf_pkg::CRF_OP_SWI || (break_enable && break_req));

  // stacked frame bytes: fetch counter low, high, index low, sum, flags
  function automatic logic [7:0] frame(input logic [2:0] k, input logic [15:0] pc,
                                       input logic [7:0] x, input logic [7:0] a,
                                       input logic [7:0] f);
    case (k)
      3'd0: frame = pc[7:0];
      3'd1: frame = pc[15:8];
      3'd2: frame = x;
      3'd3: frame = a;
      default: frame = f;
    endcase
  endfunction

  // sequencer and register set
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= crf_pkg::CRF_ST_RESV;
      step_q <= 3'd0;
      sum_q <= 8'h00;
      index_q <= 16'h0000;
      sp_q <= `CRF_STACK_RESET;
      pc_q <= 16'h0000;
      flag_q <= `CRF_FLAG_RESET;
      operand_q <= 16'h0000;
      irq_taken_q <= 4'h0;
      vec_q <= `CRF_VEC_RESET;
      trap_q <= 1'b0;
      in_break <= 1'b0;
      operand_addr <= 16'h0000;
    end else begin
      case (state_q)
        crf_pkg::CRF_ST_RESV: begin
          pc_q <= {mem[vec_q[7:0]], mem[vec_q[7:0] + 8'h01]};
          state_q <= crf_pkg::CRF_ST_IDLE;
        end
        crf_pkg::CRF_ST_IDLE: begin
          if (trap_go) begin
            trap_q <= 1'b1;
            in_break <= cmd != crf_pkg::CRF_OP_SWI;
            vec_q <= monitor_mode ? `CRF_VEC_TRAP_MON : `CRF_VEC_TRAP;
            step_q <= 3'd0;
            state_q <= crf_pkg::CRF_ST_STACK;
          end else if (irq_go) begin
            irq_taken_q <= irq_pick;
            vec_q <= `CRF_VEC_TRAP - {11'h0, irq_pick[3], irq_pick[2], irq_pick[1], 2'b00};
            step_q <= 3'd0;
            state_q <= crf_pkg::CRF_ST_STACK;
          end else if (cmd_go) begin
            sum_q <= res;
            flag_q <= flag_d | `CRF_FLAG_ONES;
            case (cmd)
              crf_pkg::CRF_OP_PUSH_A: begin
                mem[sp_q[7:0]] <= sum_q;
                sp_q <= sp_q - 16'h0001;
              end
              crf_pkg::CRF_OP_PULL_A: begin
                sp_q <= sp_q + 16'h0001;
              end
              crf_pkg::CRF_OP_PUSH_H: begin
                mem[sp_q[7:0]] <= index_q[15:8];
                sp_q <= sp_q - 16'h0001;
              end
              crf_pkg::CRF_OP_PULL_H: begin
                index_q[15:8] <= mem[sp_q[7:0] + 8'h01];
                sp_q <= sp_q + 16'h0001;
              end
              crf_pkg::CRF_OP_RSP: sp_q[7:0] <= `CRF_STACK_LOW;
              crf_pkg::CRF_OP_CLI: flag_q[`CRF_FLG_I] <= 1'b0;
              crf_pkg::CRF_OP_SEI: flag_q[`CRF_FLG_I] <= 1'b1;
              crf_pkg::CRF_OP_RTI: begin
                step_q <= 3'd4;
                state_q <= crf_pkg::CRF_ST_UNSTK;
              end
              crf_pkg::CRF_OP_FETCH: pc_q <= pc_q + 16'h0001;
              crf_pkg::CRF_OP_JUMP: pc_q <= operand_q;
              crf_pkg::CRF_OP_SPADR1: operand_addr <= sp_q + {8'h00, operand_q[7:0]};
              crf_pkg::CRF_OP_SPADR2: operand_addr <= sp_q + operand_q;
              crf_pkg::CRF_OP_LDHX: index_q <= operand_q;
              crf_pkg::CRF_OP_STOP: flag_q <= flag_q;
              default: flag_q <= flag_d | `CRF_FLAG_ONES;
            endcase
          end
        end
        crf_pkg::CRF_ST_STACK: begin
          // upper index byte is deliberately left off the frame
          mem[sp_q[7:0]] <= frame(step_q, pc_q, index_q[7:0], sum_q, flag_q);
          sp_q <= sp_q - 16'h0001;
          step_q <= step_q + 3'd1;
          if (step_q == 3'd4) begin
            state_q <= crf_pkg::CRF_ST_MASK;
          end
        end
        crf_pkg::CRF_ST_MASK: begin
          flag_q[`CRF_FLG_I] <= 1'b1;
          state_q <= crf_pkg::CRF_ST_VEC;
        end
        crf_pkg::CRF_ST_VEC: begin
          pc_q <= {mem[vec_q[7:0]], mem[vec_q[7:0] + 8'h01]};
          trap_q <= 1'b0;
          irq_taken_q <= 4'h0;
          state_q <= crf_pkg::CRF_ST_IDLE;
        end
        crf_pkg::CRF_ST_UNSTK: begin
          sp_q <= sp_q + 16'h0001;
          case (step_q)
            3'd4: flag_q <= mem[sp_q[7:0] + 8'h01] | `CRF_FLAG_ONES;
            3'd3: sum_q <= mem[sp_q[7:0] + 8'h01];
            3'd2: index_q[7:0] <= mem[sp_q[7:0] + 8'h01];
            3'd1: pc_q[15:8] <= mem[sp_q[7:0] + 8'h01];
            default: pc_q[7:0] <= mem[sp_q[7:0] + 8'h01];
          endcase
          step_q <= step_q - 3'd1;
          if (step_q == 3'd0) begin
            if (!break_req) begin
              in_break <= 1'b0;
            end
            state_q <= crf_pkg::CRF_ST_IDLE;
          end
        end
        default: state_q <= crf_pkg::CRF_ST_IDLE;
      endcase
      if (wr_go && state_q == crf_pkg::CRF_ST_IDLE && !cmd_go) begin
        if (aw_q == `CRF_OFF_SUM && ws_q[0]) sum_q <= w_q[7:0];
        if (aw_q == `CRF_OFF_INDEX) index_q <= put16(index_q, w_q, ws_q);
        if (aw_q == `CRF_OFF_STACK) sp_q <= put16(sp_q, w_q, ws_q);
        if (aw_q == `CRF_OFF_FETCH) pc_q <= put16(pc_q, w_q, ws_q);
        if (aw_q == `CRF_OFF_FLAG && ws_q[0]) flag_q <= w_q[7:0] | `CRF_FLAG_ONES;
        if (aw_q == `CRF_OFF_OPERAND) operand_q <= put16(operand_q, w_q, ws_q);
      end
      // memory image port: byte address in bits 15:8, data in bits 7:0
      if (wr_go && aw_q == `CRF_OFF_MEMDATA && ws_q[0] && ws_q[1]) begin
        mem[w_q[15:8]] <= w_q[7:0];
      end
    end
  end

  // read channel
  logic [31:0] rd_d;
  logic [7:0] ra;
  assign ra = s_axi_araddr[7:0];
  always_comb begin
    if (ra == `CRF_OFF_SUM) rd_d = {24'h0, sum_q};
    else if (ra == `CRF_OFF_INDEX) rd_d = {16'h0, index_q};
    else if (ra == `CRF_OFF_STACK) rd_d = {16'h0, sp_q};
    else if (ra == `CRF_OFF_FETCH) rd_d = {16'h0, pc_q};
    else if (ra == `CRF_OFF_FLAG) rd_d = {24'h0, flag_q | `CRF_FLAG_ONES};
    else if (ra == `CRF_OFF_OPERAND) rd_d = {16'h0, operand_q};
    else if (ra == `CRF_OFF_STATUS) rd_d = {16'h0, operand_addr};
    else if (ra == `CRF_OFF_IRQ) rd_d = {22'h0, in_break, trap_q, irq_taken_q, state_q == crf_pkg::CRF_ST_IDLE, 3'h0};
    else rd_d = 32'h0;
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_d;
        s_axi_rresp <= known(ra) ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // crf_core

// *** crf_core_monitor.sv ***
/*
  crf_core_monitor.sv: port checker for the core register and flag block.
  assumes: bound to crf_core; bench raises aw and w together.
*/
`timescale 1ns/1ps
module crf_core_monitor (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic break_req,
  input wire logic in_break,
  input wire logic [15:0] operand_addr
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed while waiting");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rvalid_cause: assert property ($rose(s_axi_rvalid) |->
    $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
  a_write_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
    else $error("write answer missing");
  a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready held");
  a_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("bad write response code");
  a_break_entry: assert property ($rose(in_break) |-> break_req)
    else $error("break entered without request");
  a_break_exit: assert property ($fell(in_break) |-> !break_req)
    else $error("break left with request high");
  a_reset_clear: assert property ($rose(arst_n) |-> !in_break &&
    operand_addr == 16'h0000 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not clear in reset");

  c_break_in: cover property ($rose(in_break));
  c_break_out: cover property ($fell(in_break));
  c_refused: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // crf_core_monitor

bind crf_core crf_core_monitor u_mon (.clock(clock), .arst_n(arst_n),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .break_req(break_req), .in_break(in_break), .operand_addr(operand_addr));

// *** crf_pkg.sv ***
/*
  crf_pkg.sv: types of the core register and flag block.
  assumes: nothing beyond a systemverilog compiler.
*/
package crf_pkg;

  // command codes written to the command register
  typedef enum logic [4:0] {
    CRF_OP_NOP     = 5'h00,
    CRF_OP_ADD     = 5'h01,
    CRF_OP_ADC     = 5'h02,
    CRF_OP_SUB     = 5'h03,
    CRF_OP_AND     = 5'h04,
    CRF_OP_LDA     = 5'h05,
    CRF_OP_ASL     = 5'h06,
    CRF_OP_ROR     = 5'h07,
    CRF_OP_DAA     = 5'h08,
    CRF_OP_PUSH_A  = 5'h09,
    CRF_OP_PULL_A  = 5'h0a,
    CRF_OP_PUSH_H  = 5'h0b,
    CRF_OP_PULL_H  = 5'h0c,
    CRF_OP_RSP     = 5'h0d,
    CRF_OP_CLI     = 5'h0e,
    CRF_OP_SEI     = 5'h0f,
    CRF_OP_RTI     = 5'h10,
    CRF_OP_SWI     = 5'h11,
    CRF_OP_FETCH   = 5'h12,
    CRF_OP_JUMP    = 5'h13,
    CRF_OP_SPADR1  = 5'h14,
    CRF_OP_SPADR2  = 5'h15,
    CRF_OP_STOP    = 5'h16,
    CRF_OP_LDHX    = 5'h17
  } crf_op_e;

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    CRF_ST_IDLE  = 6'b000001,
    CRF_ST_RESV  = 6'b000010,
    CRF_ST_STACK = 6'b000100,
    CRF_ST_MASK  = 6'b001000,
    CRF_ST_VEC   = 6'b010000,
    CRF_ST_UNSTK = 6'b100000
  } crf_state_e;

endpackage

// *** crf_req_model.sv ***
/*
  crf_req_model.sv: interrupt and break request source at the core's far side.
  assumes: one clock, active-low reset, requests set by the bench as levels.
*/
`timescale 1ns/1ps
module crf_req_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [3:0] irq_set,
  input wire logic brk_set,
  input wire logic in_break,
  output logic [3:0] irq_req,
  output logic break_req
);
  logic brk_q;
  // irq levels pass straight through; break request held until the bench drops it or the core is in break
  assign irq_req = irq_set;
  assign break_req = brk_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      brk_q <= 1'b0;
    end else if (in_break) begin
      brk_q <= 1'b0;
    end else begin
      brk_q <= brk_set;
    end
  end
endmodule // crf_req_model
